//--- qfbe_params.svh
// Constants of the queue flag bus expansion block
`ifndef QFBE_PARAMS_SVH
`define QFBE_PARAMS_SVH
`define QFBE_NQ 4
`define QFBE_Q_W 2
`define QFBE_DEV_W 3
`define QFBE_LVL_W 16
`define QFBE_DEPTH 16'h0400
`define QFBE_OFF_CTRL 8'h00
`define QFBE_OFF_AE 8'h04
`define QFBE_OFF_AF 8'h08
`define QFBE_OFF_STAT 8'h0C
`define QFBE_OFF_ISTAT 8'h10
`define QFBE_OFF_IMASK 8'h14
`define QFBE_RST_DEVID 3'h0
`define QFBE_RST_AE 16'h0008
`define QFBE_RST_AF 16'h0008
`define QFBE_RST_MASK 8'h00
`define QFBE_FIRST_WORD_FALL_THROUGH_CYC 2'h2
`define QFBE_EV_AF_POS 4
`define QFBE_ST_OWN_POS 8
`endif

//--- qfbe_pkg.sv
// Types shared by the queue flag bus expansion block
`include "qfbe_params.svh"
package qfbe_pkg;
  typedef logic [`QFBE_NQ-1:0] qfbe_qvec_t;
  typedef struct packed {
    logic stb;
    logic [`QFBE_DEV_W-1:0] dev;
    logic [`QFBE_Q_W-1:0] queue;
  } qfbe_sel_t;
endpackage : qfbe_pkg

//--- qfbe_qflag.sv
// Fill level and first flag stage of one queue
`timescale 1ns/1ps
module qfbe_qflag #(
  parameter int LW = 16,
  parameter logic [LW-1:0] DEPTH = 16'h0400
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr,
  input wire logic rd,
  input wire logic [LW-1:0] ae_off,
  input wire logic [LW-1:0] af_off,
  output logic [LW-1:0] level,
  output logic empty,
  output logic ae_n,
  output logic af_n
);
  logic [LW-1:0] level_ff;
  logic [LW-1:0] nxt_level;
  logic ae_n_ff;
  logic af_n_ff;
  logic do_wr;
  logic do_rd;

  // Overflow and underflow are refused so the count never wraps
  assign do_wr = wr && (level_ff != DEPTH);
  assign do_rd = rd && (level_ff != {LW{1'b0}});
  assign nxt_level = (do_wr && !do_rd) ? level_ff + 1'b1 :
                     (do_rd && !do_wr) ? level_ff - 1'b1 : level_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff <= {LW{1'b0}};
      ae_n_ff <= 1'b0;
      af_n_ff <= 1'b1;
    end else begin
      level_ff <= nxt_level;
      ae_n_ff <= (level_ff > ae_off);
      af_n_ff <= (level_ff < DEPTH - af_off);
    end
  end

  assign level = level_ff;
  assign empty = (level_ff == {LW{1'b0}});
  assign ae_n = ae_n_ff;
  assign af_n = af_n_ff;
endmodule : qfbe_qflag

//--- qfbe_top.sv
// Flag and status bus logic of one paralleled queue device
`timescale 1ns/1ps
`include "qfbe_params.svh"
module qfbe_top #(
  parameter int DW = 36,
  parameter int LW = `QFBE_LVL_W,
  parameter logic [`QFBE_LVL_W-1:0] DEPTH = `QFBE_DEPTH
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  input wire qfbe_pkg::qfbe_sel_t RD_SEL,
  input wire qfbe_pkg::qfbe_sel_t WR_SEL,
  input wire qfbe_pkg::qfbe_sel_t AEB_SEL,
  input wire qfbe_pkg::qfbe_sel_t AFB_SEL,
  input wire logic WR_EN_N,
  input wire logic REN_N,
  input wire logic OE_N,
  input wire logic [DW-1:0] MEM_RDATA,
  input wire logic EMPTY_BUS_CHAIN_IN,
  input wire logic FULL_BUS_CHAIN_IN,
  output logic [`QFBE_Q_W-1:0] MEM_RQ,
  output logic [DW-1:0] Q_OUT,
  output logic Q_OUT_OE_N,
  output logic ALMOST_EMPTY_FLAG,
  output logic ALMOST_EMPTY_FLAG_OE_N,
  output qfbe_pkg::qfbe_qvec_t ALMOST_EMPTY_STATUS_BUS,
  output logic ALMOST_EMPTY_STATUS_BUS_OE_N,
  output logic ALMOST_FULL_FLAG,
  output logic ALMOST_FULL_FLAG_OE_N,
  output qfbe_pkg::qfbe_qvec_t ALMOST_FULL_STATUS_BUS,
  output logic ALMOST_FULL_STATUS_BUS_OE_N,
  output logic EMPTY_BUS_CHAIN_OUT,
  output logic FULL_BUS_CHAIN_OUT
);
  import qfbe_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [`QFBE_DEV_W-1:0] dev_id_ff;
  logic [LW-1:0] ae_off_ff;
  logic [LW-1:0] af_off_ff;
  logic [7:0] int_stat_ff;
  logic [7:0] int_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic boot_ff;
  logic own_rd_ff;
  logic own_wr_ff;
  logic [`QFBE_Q_W-1:0] rq_ff;
  logic [`QFBE_Q_W-1:0] wq_ff;
  logic [1:0] first_word_fall_through_cnt_ff;
  logic [DW-1:0] q_out_ff;
  logic q_oe_n_ff;
  logic ae_flag_ff;
  logic ae_flag_oe_n_ff;
  qfbe_qvec_t ae_bus_ff;
  logic aeb_oe_n_ff;
  logic af_flag_ff;
  logic af_flag_oe_n_ff;
  qfbe_qvec_t af_bus_ff;
  logic afb_oe_n_ff;

  logic [LW-1:0] lvl [`QFBE_NQ];
  qfbe_qvec_t empty_v;
  qfbe_qvec_t ae_s1;
  qfbe_qvec_t af_s1;
  qfbe_qvec_t wr_v;
  qfbe_qvec_t rd_v;
  logic wr_evt;
  logic rd_evt;
  logic first_word_fall_through_due;
  logic nxt_own_rd;
  logic nxt_own_wr;
  logic nxt_aeb_oe_n;
  logic nxt_afb_oe_n;
  logic [1:0] nxt_first_word_fall_through_cnt;
  logic apb_setup;
  logic apb_wr;
  logic apb_mapped;
  logic [31:0] apb_rdata;
  logic [31:0] stat_word;
  logic [7:0] evts;
  logic [7:0] w1c;
  logic [7:0] nxt_int_stat;

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  function automatic logic sel_me(input qfbe_sel_t s, input logic [`QFBE_DEV_W-1:0] id);
    sel_me = (s.dev == id);
  endfunction : sel_me

  //////////////////////////////////////////////////////////////////////////////
  // Queues

  genvar gi;
  generate
    for (gi = 0; gi < `QFBE_NQ; gi++) begin : g_q
      assign wr_v[gi] = wr_evt && (wq_ff == `QFBE_Q_W'(gi));
      assign rd_v[gi] = rd_evt && (rq_ff == `QFBE_Q_W'(gi));
      qfbe_qflag #(
        .LW(LW),
        .DEPTH(DEPTH)
      ) u_qflag (
        .clk(REF_CLK),
        .rst(RESET),
        .wr(wr_v[gi]),
        .rd(rd_v[gi]),
        .ae_off(ae_off_ff),
        .af_off(af_off_ff),
        .level(lvl[gi]),
        .empty(empty_v[gi]),
        .ae_n(ae_s1[gi]),
        .af_n(af_s1[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read side: queue select, fall-through and read events

  // One forced read two clocks after a queue switch, REN_N not consulted
  assign first_word_fall_through_due = (first_word_fall_through_cnt_ff == 2'h1);
  assign rd_evt = own_rd_ff && !empty_v[rq_ff] && (!REN_N || first_word_fall_through_due);
  assign nxt_own_rd = RD_SEL.stb ? sel_me(RD_SEL, dev_id_ff) : own_rd_ff;
  assign nxt_first_word_fall_through_cnt = (RD_SEL.stb && sel_me(RD_SEL, dev_id_ff)) ? `QFBE_FIRST_WORD_FALL_THROUGH_CYC :
                        (RD_SEL.stb || first_word_fall_through_cnt_ff == 2'h0) ? 2'h0 :
                        first_word_fall_through_cnt_ff - 2'h1;
  // Master takes bus ownership from its tied-low chain input once after reset
  assign nxt_aeb_oe_n = AEB_SEL.stb ? !sel_me(AEB_SEL, dev_id_ff) :
                        boot_ff ? EMPTY_BUS_CHAIN_IN : aeb_oe_n_ff;

  // Read side selection registers kept apart from the write side
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      own_rd_ff <= 1'b0;
      rq_ff <= 2'h0;
      first_word_fall_through_cnt_ff <= 2'h0;
      aeb_oe_n_ff <= 1'b1;
    end else begin
      own_rd_ff <= nxt_own_rd;
      rq_ff <= RD_SEL.stb ? RD_SEL.queue : rq_ff;
      first_word_fall_through_cnt_ff <= nxt_first_word_fall_through_cnt;
      aeb_oe_n_ff <= nxt_aeb_oe_n;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ae_flag_ff <= 1'b0;
      ae_flag_oe_n_ff <= 1'b1;
      ae_bus_ff <= 4'h0;
      q_out_ff <= {DW{1'b0}};
      q_oe_n_ff <= 1'b1;
    end else begin
      ae_flag_ff <= ae_s1[nxt_own_rd ? (RD_SEL.stb ? RD_SEL.queue : rq_ff) : rq_ff];
      ae_flag_oe_n_ff <= !nxt_own_rd;
      ae_bus_ff <= ae_s1;
      q_out_ff <= rd_evt ? MEM_RDATA : q_out_ff;
      q_oe_n_ff <= OE_N || !own_rd_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Write side: queue select, bus select and write events

  assign wr_evt = own_wr_ff && !WR_EN_N;
  assign nxt_own_wr = WR_SEL.stb ? sel_me(WR_SEL, dev_id_ff) : own_wr_ff;
  // Bus owner select is a separate strobe from the write queue select
  assign nxt_afb_oe_n = AFB_SEL.stb ? !sel_me(AFB_SEL, dev_id_ff) :
                        boot_ff ? FULL_BUS_CHAIN_IN : afb_oe_n_ff;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      own_wr_ff <= 1'b0;
      wq_ff <= 2'h0;
      afb_oe_n_ff <= 1'b1;
      af_flag_ff <= 1'b1;
      af_flag_oe_n_ff <= 1'b1;
      af_bus_ff <= 4'hF;
    end else begin
      own_wr_ff <= nxt_own_wr;
      wq_ff <= WR_SEL.stb ? WR_SEL.queue : wq_ff;
      afb_oe_n_ff <= nxt_afb_oe_n;
      af_flag_ff <= af_s1[WR_SEL.stb ? WR_SEL.queue : wq_ff];
      af_flag_oe_n_ff <= !nxt_own_wr;
      af_bus_ff <= af_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave and interrupt

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE && pready_ff;
  assign apb_mapped = hit(PADDR, `QFBE_OFF_CTRL) || hit(PADDR, `QFBE_OFF_AE) ||
                      hit(PADDR, `QFBE_OFF_AF) || hit(PADDR, `QFBE_OFF_STAT) ||
                      hit(PADDR, `QFBE_OFF_ISTAT) || hit(PADDR, `QFBE_OFF_IMASK);
  assign stat_word = {20'h0_0000, !afb_oe_n_ff, !aeb_oe_n_ff, own_wr_ff, own_rd_ff,
                      af_s1, ae_s1};
  assign apb_rdata = hit(PADDR, `QFBE_OFF_CTRL) ? {29'h0000_0000, dev_id_ff} :
                     hit(PADDR, `QFBE_OFF_AE) ? {16'h0000, ae_off_ff} :
                     hit(PADDR, `QFBE_OFF_AF) ? {16'h0000, af_off_ff} :
                     hit(PADDR, `QFBE_OFF_STAT) ? stat_word :
                     hit(PADDR, `QFBE_OFF_ISTAT) ? {24'h00_0000, int_stat_ff} :
                     hit(PADDR, `QFBE_OFF_IMASK) ? {24'h00_0000, int_mask_ff} :
                     32'h0000_0000;
  // Events: a queue entering almost empty or almost full at the first stage
  assign evts = {af_bus_ff & ~af_s1, ae_bus_ff & ~ae_s1};
  assign w1c = (apb_wr && hit(PADDR, `QFBE_OFF_ISTAT)) ? PWDATA[7:0] : 8'h00;
  // A new event wins over a clear in the same cycle
  assign nxt_int_stat = (int_stat_ff & ~w1c) | evts;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dev_id_ff <= `QFBE_RST_DEVID;
      ae_off_ff <= `QFBE_RST_AE;
      af_off_ff <= `QFBE_RST_AF;
      int_mask_ff <= `QFBE_RST_MASK;
    end else if (apb_wr) begin
      if (hit(PADDR, `QFBE_OFF_CTRL)) begin
        dev_id_ff <= PWDATA[`QFBE_DEV_W-1:0];
      end else if (hit(PADDR, `QFBE_OFF_AE)) begin
        ae_off_ff <= PWDATA[LW-1:0];
      end else if (hit(PADDR, `QFBE_OFF_AF)) begin
        af_off_ff <= PWDATA[LW-1:0];
      end else if (hit(PADDR, `QFBE_OFF_IMASK)) begin
        int_mask_ff <= PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      int_stat_ff <= 8'h00;
      irq_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      boot_ff <= 1'b1;
    end else begin
      int_stat_ff <= nxt_int_stat;
      irq_ff <= |(nxt_int_stat & int_mask_ff);
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup && !apb_mapped;
      prdata_ff <= (apb_setup && !PWRITE) ? apb_rdata : prdata_ff;
      boot_ff <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign IRQ = irq_ff;
  assign MEM_RQ = rq_ff;
  assign Q_OUT = q_out_ff;
  assign Q_OUT_OE_N = q_oe_n_ff;
  assign ALMOST_EMPTY_FLAG = ae_flag_ff;
  assign ALMOST_EMPTY_FLAG_OE_N = ae_flag_oe_n_ff;
  assign ALMOST_EMPTY_STATUS_BUS = ae_bus_ff;
  assign ALMOST_EMPTY_STATUS_BUS_OE_N = aeb_oe_n_ff;
  assign ALMOST_FULL_FLAG = af_flag_ff;
  assign ALMOST_FULL_FLAG_OE_N = af_flag_oe_n_ff;
  assign ALMOST_FULL_STATUS_BUS = af_bus_ff;
  assign ALMOST_FULL_STATUS_BUS_OE_N = afb_oe_n_ff;
  // Chain outputs are not used in direct mode; held low
  assign EMPTY_BUS_CHAIN_OUT = boot_ff & 1'b0;
  assign FULL_BUS_CHAIN_OUT = boot_ff & 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [LW-1:0] lvl_r;
  logic [LW-1:0] lvl_w;
  logic [LW-1:0] ae_edge;
  logic [LW-1:0] af_edge;
  qfbe_qvec_t ae_raw;

  assign lvl_r = lvl[rq_ff];
  assign lvl_w = lvl[wq_ff];
  assign ae_edge = ae_off_ff + 1'b1;
  assign af_edge = DEPTH - af_off_ff;
  generate
    for (gi = 0; gi < `QFBE_NQ; gi++) begin : g_raw
      assign ae_raw[gi] = (lvl[gi] > ae_off_ff);
    end
  endgenerate

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_ae_assert_two: assert property (
    (rd_evt && lvl_r == ae_edge && !wr_v[rq_ff] && !RD_SEL.stb) ##1 !RD_SEL.stb
    ##1 !RD_SEL.stb |-> ##1 !ALMOST_EMPTY_FLAG)
    else $error("almost empty flag not low two clocks after boundary read");

  a_ae_release_write: assert property (
    (wr_v[rq_ff] && lvl_r == ae_off_ff && !rd_v[rq_ff] && !RD_SEL.stb) ##1 !RD_SEL.stb
    ##1 !RD_SEL.stb |-> ##1 ALMOST_EMPTY_FLAG)
    else $error("almost empty flag not high after write past boundary");

  a_aeb_take_bus: assert property (
    AEB_SEL.stb && AEB_SEL.dev == dev_id_ff |=> !ALMOST_EMPTY_STATUS_BUS_OE_N)
    else $error("selected device does not drive almost empty bus");

  a_aeb_release_bus: assert property (
    AEB_SEL.stb && AEB_SEL.dev != dev_id_ff |=> ALMOST_EMPTY_STATUS_BUS_OE_N)
    else $error("deselected device still drives almost empty bus");

  a_ae_bus_map: assert property (
    ALMOST_EMPTY_STATUS_BUS == $past(ae_raw, 2))
    else $error("almost empty bus bit does not match queue level");

  a_ae_flag_float: assert property (
    !nxt_own_rd |=> ALMOST_EMPTY_FLAG_OE_N)
    else $error("almost empty flag driven without read queue ownership");

  a_afb_prev_cycle: assert property (
    AFB_SEL.stb |=> ALMOST_FULL_STATUS_BUS_OE_N == ($past(AFB_SEL.dev) != $past(dev_id_ff)))
    else $error("almost full bus owner not taken from previous cycle");

  a_af_release_read: assert property (
    (rd_v[wq_ff] && lvl_w == af_edge && !wr_v[wq_ff] && !WR_SEL.stb) ##1 !WR_SEL.stb
    ##1 !WR_SEL.stb |-> ##1 ALMOST_FULL_FLAG && ALMOST_FULL_STATUS_BUS[$past(wq_ff, 3)])
    else $error("almost full flag not high after boundary read");

  a_af_drive_flag: assert property (
    WR_SEL.stb && WR_SEL.dev == dev_id_ff |=> !ALMOST_FULL_FLAG_OE_N [*1])
    else $error("write queue owner does not drive almost full flag");

  a_af_assert_two: assert property (
    (wr_v[wq_ff] && lvl_w == af_edge - 1'b1 && !rd_v[wq_ff] && !WR_SEL.stb)
    ##1 !WR_SEL.stb ##1 !WR_SEL.stb |-> ##1 !ALMOST_FULL_FLAG)
    else $error("almost full flag not low two clocks after boundary write");

  a_first_word_fall_through_fall: assert property (
    (RD_SEL.stb && RD_SEL.dev == dev_id_ff) ##1 !RD_SEL.stb
    ##1 (!RD_SEL.stb && !empty_v[rq_ff]) |-> rd_evt)
    else $error("no fall-through read two clocks after queue select");

  a_ren_blocks: assert property (
    REN_N && first_word_fall_through_cnt_ff != 2'h1 |-> !rd_evt ##1 $stable(q_out_ff))
    else $error("read taken while read enable inactive");

  a_q_out_drive: assert property (
    !OE_N && own_rd_ff |=> !Q_OUT_OE_N &&
    Q_OUT == ($past(rd_evt) ? $past(MEM_RDATA) : $past(Q_OUT)))
    else $error("read bus not driven with output enable low");
endmodule : qfbe_top

//--- qfbe_far_model.sv
// Far side model: queue memory read port and one other paralleled device
`timescale 1ns/1ps
module qfbe_far_model #(
  parameter int DW = 36,
  parameter logic [2:0] OTHER_ID = 3'h5
) (
  input wire logic clk,
  input wire logic [1:0] mem_rq,
  input wire qfbe_pkg::qfbe_sel_t aeb_sel,
  input wire qfbe_pkg::qfbe_sel_t afb_sel,
  input wire logic ae_oe_n,
  input wire logic af_oe_n,
  output logic [DW-1:0] mem_rdata,
  output logic clash
);
  import qfbe_pkg::*;
  logic ae_own_ff = 1'b0;
  logic af_own_ff = 1'b0;
  logic [31:0] cyc_ff = 32'h0000_0000;
  ////////////////////////////////////////////////////////////////
  // The other device is strapped high, so it owns neither bus at first
  always @(posedge clk) begin
    cyc_ff <= cyc_ff + 32'h0000_0001;
    if (aeb_sel.stb) begin
      ae_own_ff <= (aeb_sel.dev == OTHER_ID);
    end
    if (afb_sel.stb) begin
      af_own_ff <= (afb_sel.dev == OTHER_ID);
    end
  end
  // A fresh word every cycle, so a read taken on the wrong edge shows up
  assign mem_rdata = DW'({mem_rq, cyc_ff});
  // Both parties driving one bus in the same cycle is contention
  assign clash = (!ae_oe_n && ae_own_ff) || (!af_oe_n && af_own_ff);
endmodule : qfbe_far_model

//--- queue_flag_bus_expansion_bench.sv
// Self-checking bench of the queue flag bus expansion block
`timescale 1ns/1ps
`include "qfbe_params.svh"
module queue_flag_bus_expansion_bench;
  import qfbe_pkg::*;
  localparam int DW = 36;
  localparam logic [15:0] DEPTH = 16'h0010;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  qfbe_sel_t sel [4] = '{default: '0};
  logic wr_en_n = 1'b1;
  logic ren_n = 1'b1;
  logic oe_n = 1'b1;
  logic [DW-1:0] mem_rdata;
  logic [1:0] mem_rq;
  logic [DW-1:0] q_out;
  logic q_oe_n;
  logic ae_flag;
  logic ae_flag_oe_n;
  qfbe_qvec_t ae_bus;
  logic ae_oe_n;
  logic af_flag;
  logic af_flag_oe_n;
  qfbe_qvec_t af_bus;
  logic af_oe_n;
  logic clash;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int lvl [4] = '{0, 0, 0, 0};
  int rq = 0;
  int wq = 0;
  int fw = 0;
  int quiet = 0;
  int boot = 2;
  int ae_off = 8;
  int af_off = 8;
  bit own_rd = 1'b0;
  bit own_wr = 1'b0;
  bit own_aeb = 1'b1;
  bit own_afb = 1'b1;
  bit rd;
  bit wr;
  qfbe_qvec_t exp_ae = 4'h0;
  qfbe_qvec_t exp_af = 4'hF;
  qfbe_qvec_t stage_ae = 4'h0;
  qfbe_qvec_t stage_af = 4'hF;
  logic [1:0] chain_out;
  logic exp_aef;
  logic exp_aff;
  logic exp_qoe = 1'b1;
  logic [DW-1:0] exp_q = '0;
  logic [31:0] rdat;
  logic rerr;
  int unsigned seed;

  qfbe_top #(.DW(DW), .DEPTH(DEPTH)) uut (
    .REF_CLK(clk),
    .RESET(rst),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr),
    .IRQ(irq),
    .RD_SEL(sel[0]),
    .WR_SEL(sel[1]),
    .AEB_SEL(sel[2]),
    .AFB_SEL(sel[3]),
    .WR_EN_N(wr_en_n),
    .REN_N(ren_n),
    .OE_N(oe_n),
    .MEM_RDATA(mem_rdata),
    .EMPTY_BUS_CHAIN_IN(1'b0),
    .FULL_BUS_CHAIN_IN(1'b0),
    .MEM_RQ(mem_rq),
    .Q_OUT(q_out),
    .Q_OUT_OE_N(q_oe_n),
    .ALMOST_EMPTY_FLAG(ae_flag),
    .ALMOST_EMPTY_FLAG_OE_N(ae_flag_oe_n),
    .ALMOST_EMPTY_STATUS_BUS(ae_bus),
    .ALMOST_EMPTY_STATUS_BUS_OE_N(ae_oe_n),
    .ALMOST_FULL_FLAG(af_flag),
    .ALMOST_FULL_FLAG_OE_N(af_flag_oe_n),
    .ALMOST_FULL_STATUS_BUS(af_bus),
    .ALMOST_FULL_STATUS_BUS_OE_N(af_oe_n),
    .EMPTY_BUS_CHAIN_OUT(chain_out[0]),
    .FULL_BUS_CHAIN_OUT(chain_out[1])
  );
  qfbe_far_model #(.DW(DW)) far (
    .clk(clk),
    .mem_rq(mem_rq),
    .aeb_sel(sel[2]),
    .afb_sel(sel[3]),
    .ae_oe_n(ae_oe_n),
    .af_oe_n(af_oe_n),
    .mem_rdata(mem_rdata),
    .clash(clash)
  );

  initial forever #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    check(rdat, e);
    check(rerr, ee);
  endtask : reg_chk

  task automatic pick(input int k, input logic [2:0] d, input logic [1:0] q);
    sel[k] <= '{stb: 1'b1, dev: d, queue: q};
    @(posedge clk);
    sel[k] <= '0;
    @(posedge clk);
  endtask : pick

  // Mode 0 idle, 1 write, 2 read, 3 random mix; output enable is always random
  task automatic run(input int n, input int mode);
    repeat (n) begin
      wr_en_n <= !(mode == 1 || (mode == 3 && $urandom % 2 == 1));
      ren_n <= !(mode == 2 || (mode == 3 && $urandom % 2 == 1));
      oe_n <= 1'($urandom % 2);
      @(posedge clk);
    end
  endtask : run
  ////////////////////////////////////////////////////////////////
  // Reference model; flags follow the level with two clocks of registering
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      final_report();
    end
    if (!rst) begin
      if (boot > 0) boot--;
      if (quiet > 0) quiet--;
      exp_ae = stage_ae;
      exp_af = stage_af;
      for (int n = 0; n < 4; n++) begin
        stage_ae[n] = lvl[n] > ae_off;
        stage_af[n] = lvl[n] < int'(DEPTH) - af_off;
      end
      exp_aef = exp_ae[rq];
      exp_aff = exp_af[wq];
      exp_qoe = oe_n | !own_rd;
      rd = own_rd && lvl[rq] > 0 && (!ren_n || fw == 1);
      wr = own_wr && !wr_en_n && lvl[wq] < int'(DEPTH);
      if (rd) exp_q = mem_rdata;
      lvl[rq] -= int'(rd);
      lvl[wq] += int'(wr);
      if (fw > 0) fw--;
      if (sel[0].stb) begin
        own_rd = sel[0].dev == 3'h0;
        rq = int'(sel[0].queue);
        fw = 2;
        quiet = 4;
      end
      if (sel[1].stb) begin
        own_wr = sel[1].dev == 3'h0;
        wq = int'(sel[1].queue);
        quiet = 4;
      end
      if (sel[2].stb) own_aeb = sel[2].dev == 3'h0;
      if (sel[3].stb) own_afb = sel[3].dev == 3'h0;
    end
  end

  // Ownership is checked every cycle once boot reaches zero; values wait out a select's settling
  always @(negedge clk) begin
    if (!rst && boot == 0) begin
      check(ae_oe_n, !own_aeb);
      check(af_oe_n, !own_afb);
      check(ae_flag_oe_n, !own_rd);
      check(af_flag_oe_n, !own_wr);
      check(clash, 1'b0);
      check(chain_out, 2'h0);
    end
    if (!rst && quiet == 0) begin
      check(ae_bus, exp_ae);
      check(af_bus, exp_af);
      if (own_rd) check(ae_flag, exp_aef);
      if (own_wr) check(af_flag, exp_aff);
      check(q_out, exp_q);
      check(q_oe_n, exp_qoe);
      check(mem_rq, rq[1:0]);
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'hcbbe);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    reg_chk(`QFBE_OFF_CTRL, 32'h0000_0000, 1'b0);
    reg_chk(`QFBE_OFF_AE, 32'h0000_0008, 1'b0);
    reg_chk(`QFBE_OFF_AF, 32'h0000_0008, 1'b0);
    reg_chk(`QFBE_OFF_IMASK, 32'h0000_0000, 1'b0);
    reg_chk(`QFBE_OFF_STAT, 32'h0000_0CF0, 1'b0);
    reg_chk(8'h3C, 32'h0000_0000, 1'b1);
    apb(1'b1, `QFBE_OFF_AE, 32'h0000_0002);
    ae_off = 2;
    apb(1'b1, `QFBE_OFF_AF, 32'h0000_0003);
    af_off = 3;
    quiet = 6;
    apb(1'b1, `QFBE_OFF_ISTAT, 32'h0000_00FF);
    pick(2, 3'h5, 2'h0);
    pick(3, 3'h5, 2'h0);
    run(4, 0);
    pick(2, 3'h0, 2'h0);
    pick(3, 3'h0, 2'h0);
    pick(0, 3'h0, 2'h1);
    pick(1, 3'h0, 2'h1);
    // One write more than the depth, so the last one is refused
    run(17, 1);
    run(4, 0);
    run(17, 2);
    run(4, 0);
    reg_chk(`QFBE_OFF_ISTAT, 32'h0000_0022, 1'b0);
    check(irq, 1'b0);
    apb(1'b1, `QFBE_OFF_IMASK, 32'h0000_0002);
    run(2, 0);
    check(irq, 1'b1);
    apb(1'b1, `QFBE_OFF_ISTAT, 32'h0000_0002);
    run(2, 0);
    check(irq, 1'b0);
    reg_chk(`QFBE_OFF_ISTAT, 32'h0000_0020, 1'b0);
    run(5, 1);
    run(2, 0);
    pick(0, 3'h3, 2'h2);
    run(3, 0);
    pick(0, 3'h0, 2'h1);
    run(6, 0);
    run(60, 3);
    run(2, 0);
    pick(1, 3'h6, 2'h2);
    run(10, 3);
    final_report();
  end
endmodule : queue_flag_bus_expansion_bench
